/* File: design/fess_ctrl.sv */
// host controller for chip erase, suspend, resume and status polling
// Operation
// - erase starts with two unlock writes then 80h at 5555h.
// - two more unlock writes then 10h begin the chip erase.
// - a failed erase is cleared only by a read_reset command.
// - erase_suspend is one B0h write, honoured only while erasing.
// - suspended: only resume, program, read and read_reset; program outside erased blocks.
// - resume_cmd is one 30h write at any address.
`timescale 1ns/100ps
module fess_ctrl #(
  parameter logic [18:0] UNLOCK1_ADDR = 19'h05555,
  parameter logic [7:0] UNLOCK1_DATA = 8'haa,
  parameter logic [18:0] UNLOCK2_ADDR = 19'h02aaa,
  parameter logic [7:0] UNLOCK2_DATA = 8'h55,
  parameter logic [7:0] READ_RESET_CODE = 8'hf0,
  parameter logic [7:0] PROGRAM_CODE = 8'ha0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic supply_low,
  output logic [18:0] fl_addr,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [7:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_SEQ_WAIT, ST_POLL,
    ST_POLL_WAIT} fess_state_e;
  typedef enum logic [1:0] {PH_READY, PH_ERASING, PH_SUSPENDED, PH_FAILED}
    fess_phase_e;

  fess_state_e state_r;
  fess_phase_e phase_r;
  logic [2:0] op_r;
  logic [2:0] step_r;
  logic [18:0] addr_r;
  logic [7:0] data_r;
  logic pend_r;
  logic [2:0] pend_op_r;
  logic refused_r;
  logic [7:0] fstat_r;
  logic [7:0] rdata_r;
  logic prev_tog_r;
  logic prev_vld_r;
  logic [9:0] timer_r;
  logic bus_start_r;
  logic bus_wr_r;
  logic [18:0] bus_addr_r;
  logic [7:0] bus_wdata_r;
  logic bus_done;
  logic [7:0] bus_rdata;
  logic take;
  logic reject;
  logic ctrl_wr;
  logic stopped;

  // number of flash cycles each operation issues
  function automatic logic [2:0] seq_len(input logic [2:0] op);
    case (op)
      fess_pkg::OP_ERASE: seq_len = 3'h6;
      fess_pkg::OP_PROG: seq_len = 3'h4;
      default: seq_len = 3'h1;
    endcase
  endfunction

  // address and data of each flash cycle
  function automatic logic [26:0] seq_word(input logic [2:0] op,
    input logic [2:0] step, input logic [18:0] a, input logic [7:0] d);
    logic [26:0] u1;
    logic [26:0] u2;
    u1 = {UNLOCK1_ADDR, UNLOCK1_DATA};
    u2 = {UNLOCK2_ADDR, UNLOCK2_DATA};
    seq_word = {a, d};
    case (op)
      fess_pkg::OP_ERASE: begin
        case (step)
          3'h0, 3'h3: seq_word = u1;
          3'h1, 3'h4: seq_word = u2;
          3'h2: seq_word = {fess_pkg::SETUP_ADDR, fess_pkg::CMD_SETUP};
          default: seq_word = {a, fess_pkg::CMD_CHIP_ERASE};
        endcase
      end
      fess_pkg::OP_PROG: begin
        case (step)
          3'h0: seq_word = u1;
          3'h1: seq_word = u2;
          3'h2: seq_word = {fess_pkg::SETUP_ADDR, PROGRAM_CODE};
          default: seq_word = {a, d};
        endcase
      end
      fess_pkg::OP_SUSPEND: seq_word = {a, fess_pkg::CMD_SUSPEND};
      fess_pkg::OP_RESUME: seq_word = {a, fess_pkg::CMD_RESUME};
      fess_pkg::OP_RESET: seq_word = {a, READ_RESET_CODE};
      default: seq_word = {a, d};
    endcase
  endfunction

  // which orders the device will honour in each phase
  function automatic logic allowed(input fess_phase_e ph,
    input logic [2:0] op, input logic low);
    allowed = 1'b0;
    if (!(low && op != fess_pkg::OP_READ)) begin
      case (ph)
        PH_READY: allowed = (op != fess_pkg::OP_SUSPEND) &&
                            (op != fess_pkg::OP_RESUME);
        PH_ERASING: allowed = (op == fess_pkg::OP_SUSPEND) ||
                              (op == fess_pkg::OP_RESET);
        PH_SUSPENDED: allowed = (op == fess_pkg::OP_RESUME) ||
                                (op == fess_pkg::OP_PROG) ||
                                (op == fess_pkg::OP_READ) ||
                                (op == fess_pkg::OP_RESET);
        PH_FAILED: allowed = (op == fess_pkg::OP_RESET) ||
                             (op == fess_pkg::OP_READ);
        default: allowed = 1'b0;
      endcase
    end
  endfunction

  assign ctrl_wr = reg_wr && (reg_addr == fess_pkg::CTRL_OFF) &&
                   (reg_wdata[2:0] != fess_pkg::OP_NONE);
  // a running erase may be interrupted between status reads
  assign take = pend_r && ((state_r == ST_IDLE) || ((state_r == ST_POLL) &&
                (op_r == fess_pkg::OP_ERASE || op_r == fess_pkg::OP_RESUME)));
  assign reject = take && !allowed(phase_r, pend_op_r, supply_low);
  assign stopped = prev_vld_r && (bus_rdata[fess_pkg::TOGGLE_A] == prev_tog_r);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= 19'h00000;
      data_r <= 8'h00;
    end else if (reg_wr && reg_addr == fess_pkg::ADDR_OFF) begin
      addr_r <= reg_wdata[18:0];
    end else if (reg_wr && reg_addr == fess_pkg::DATA_OFF) begin
      data_r <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
      pend_op_r <= fess_pkg::OP_NONE;
    end else if (ctrl_wr && !pend_r) begin
      pend_r <= 1'b1;
      pend_op_r <= reg_wdata[2:0];
    end else if (take) begin
      pend_r <= 1'b0;
    end
  end

  // sticky refusal; a new refusal wins over a software clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      refused_r <= 1'b0;
    end else if (reject || (ctrl_wr && pend_r)) begin
      refused_r <= 1'b1;
    end else if (reg_wr && reg_addr == fess_pkg::STAT_OFF &&
                 reg_wdata[fess_pkg::ST_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      phase_r <= PH_READY;
      op_r <= fess_pkg::OP_NONE;
      step_r <= 3'h0;
      fstat_r <= 8'h00;
      rdata_r <= 8'h00;
      prev_tog_r <= 1'b0;
      prev_vld_r <= 1'b0;
      timer_r <= 10'h000;
      bus_start_r <= 1'b0;
      bus_wr_r <= 1'b0;
      bus_addr_r <= 19'h00000;
      bus_wdata_r <= 8'h00;
    end else begin
      bus_start_r <= 1'b0;
      if (timer_r != 10'h3ff) begin
        timer_r <= timer_r + 10'h001;
      end
      if (take && !reject) begin
        op_r <= pend_op_r;
        step_r <= 3'h0;
        state_r <= ST_SEQ;
      end else begin
        case (state_r)
          ST_SEQ: begin
            bus_start_r <= 1'b1;
            bus_wr_r <= (op_r != fess_pkg::OP_READ);
            {bus_addr_r, bus_wdata_r} <= seq_word(op_r, step_r, addr_r,
                                                  data_r);
            state_r <= ST_SEQ_WAIT;
          end
          ST_SEQ_WAIT: begin
            if (bus_done) begin
              prev_vld_r <= 1'b0;
              timer_r <= 10'h000;
              if (step_r + 3'h1 < seq_len(op_r)) begin
                step_r <= step_r + 3'h1;
                state_r <= ST_SEQ;
              end else begin
                case (op_r)
                  fess_pkg::OP_ERASE, fess_pkg::OP_RESUME: begin
                    phase_r <= PH_ERASING;
                    state_r <= ST_POLL;
                  end
                  fess_pkg::OP_SUSPEND, fess_pkg::OP_PROG:
                    state_r <= ST_POLL;
                  fess_pkg::OP_RESET: begin
                    phase_r <= PH_READY;
                    state_r <= ST_IDLE;
                  end
                  default: begin
                    rdata_r <= bus_rdata;
                    state_r <= ST_IDLE;
                  end
                endcase
              end
            end
          end
          ST_POLL: begin
            bus_start_r <= 1'b1;
            bus_wr_r <= 1'b0;
            bus_addr_r <= addr_r;
            state_r <= ST_POLL_WAIT;
          end
          ST_POLL_WAIT: begin
            if (bus_done) begin
              fstat_r <= bus_rdata;
              prev_tog_r <= bus_rdata[fess_pkg::TOGGLE_A];
              prev_vld_r <= 1'b1;
              state_r <= ST_POLL;
              case (op_r)
                fess_pkg::OP_SUSPEND: begin
                  if ((stopped && timer_r >= 10'(fess_pkg::SUSP_MIN_CYC)) ||
                      timer_r >= 10'(fess_pkg::SUSP_MAX_CYC)) begin
                    phase_r <= PH_SUSPENDED;
                    state_r <= ST_IDLE;
                  end
                end
                fess_pkg::OP_PROG: begin
                  if (stopped) begin
                    state_r <= ST_IDLE;
                  end
                end
                default: begin
                  if (stopped) begin
                    // erased data reads ffh, fail bit included, so a
                    // failure also needs the poll bit still low
                    phase_r <= (bus_rdata[fess_pkg::FAIL_BIT] &&
                                !bus_rdata[fess_pkg::POLL_BIT]) ?
                               PH_FAILED : PH_READY;
                    state_r <= ST_IDLE;
                  end
                end
              endcase
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        fess_pkg::ADDR_OFF: reg_rdata <= {13'h0000, addr_r};
        fess_pkg::DATA_OFF: reg_rdata <= {24'h000000, data_r};
        fess_pkg::STAT_OFF: reg_rdata <= {8'h00, rdata_r, fstat_r, 3'h0,
          refused_r, phase_r, pend_r, (state_r != ST_IDLE)};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  fess_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(bus_start_r),
    .wr(bus_wr_r),
    .addr(bus_addr_r),
    .wdata(bus_wdata_r),
    .done(bus_done),
    .rdata(bus_rdata),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );
endmodule

/* File: shared/fess_pkg.sv */
// constants shared by the flash erase/suspend host controller
package fess_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  // software register offsets (byte addresses)
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] ADDR_OFF = 4'h4;
  localparam logic [3:0] DATA_OFF = 4'h8;
  localparam logic [3:0] STAT_OFF = 4'hc;
  // control word operation codes, bits [2:0]
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_ERASE = 3'h1;
  localparam logic [2:0] OP_SUSPEND = 3'h2;
  localparam logic [2:0] OP_RESUME = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam logic [2:0] OP_PROG = 3'h5;
  localparam logic [2:0] OP_READ = 3'h6;
  // status word fields
  localparam int ST_BUSY = 0;
  localparam int ST_PEND = 1;
  localparam int ST_PHASE_LO = 2;
  localparam int ST_REFUSED = 4;
  localparam int ST_FSTAT_LO = 8;
  localparam int ST_RDATA_LO = 16;
  // device command bytes and fixed address
  localparam logic [7:0] CMD_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [18:0] SETUP_ADDR = 19'h05555;
  // device status bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_A = 6;
  localparam int FAIL_BIT = 5;
  localparam int TIMEOUT_BIT = 3;
  localparam int TOGGLE_B = 2;
  // timing
  localparam int CLK_NS = 25;
  localparam int WE_PULSE_NS = 50;
  localparam int RD_ACCESS_NS = 100;
  localparam int RECOVER_NS = 30;
  localparam int SUSP_MIN_NS = 100;
  localparam int SUSP_MAX_NS = 15000;
  localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_MIN_CYC = (SUSP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_MAX_CYC = SUSP_MAX_NS / CLK_NS;
endpackage

/* File: design/fess_bus_cycle.sv */
// one write or read cycle on the flash pins
`timescale 1ns/100ps
module fess_bus_cycle (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic wr,
  input wire logic [18:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [18:0] fl_addr,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [7:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_PULSE, BC_RECOV}
    fess_bc_e;
  fess_bc_e st_r;
  logic wr_r;
  logic [2:0] cnt_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= BC_IDLE;
      wr_r <= 1'b0;
      cnt_r <= 3'h0;
      done <= 1'b0;
      rdata <= 8'h00;
      fl_addr <= 19'h00000;
      fl_dq_o <= 8'h00;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st_r)
        BC_IDLE: begin
          if (start) begin
            // address and data settle before the strobe falls
            wr_r <= wr;
            fl_addr <= addr;
            fl_dq_o <= wdata;
            fl_dq_oe <= wr;
            fl_ce_n <= 1'b0;
            st_r <= BC_SETUP;
          end
        end
        BC_SETUP: begin
          // address taken on the falling edge of write enable
          fl_we_n <= !wr_r;
          fl_oe_n <= wr_r;
          cnt_r <= wr_r ? 3'(fess_pkg::WE_PULSE_CYC - 1) :
                          3'(fess_pkg::RD_ACCESS_CYC - 1);
          st_r <= BC_PULSE;
        end
        BC_PULSE: begin
          if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
          end else begin
            // data taken on the rising edge, held one more cycle
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            if (!wr_r) begin
              rdata <= fl_dq_i;
            end
            cnt_r <= 3'(fess_pkg::RECOVER_CYC);
            st_r <= BC_RECOV;
          end
        end
        BC_RECOV: begin
          fl_ce_n <= 1'b1;
          fl_dq_oe <= 1'b0;
          if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
          end else begin
            done <= 1'b1;
            st_r <= BC_IDLE;
          end
        end
        default: st_r <= BC_IDLE;
      endcase
    end
  end
endmodule

/* File: tb/fess_ctrl_assertions.sv */
// pin-level checks for the flash erase/suspend controller
`timescale 1ns/100ps
module fess_ctrl_assertions #(
  parameter logic [18:0] UNLOCK1_ADDR = 19'h05555,
  parameter logic [7:0] UNLOCK1_DATA = 8'haa,
  parameter logic [18:0] UNLOCK2_ADDR = 19'h02aaa,
  parameter logic [7:0] UNLOCK2_DATA = 8'h55
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic supply_low,
  input wire logic [18:0] fl_addr,
  input wire logic [7:0] fl_dq_o,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n
);
  logic we_q_r, wstb;
  logic [1:0] code_nxt, h1_r, h2_r, h3_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // kind of write just ended: 1 first unlock, 2 second unlock, 3 set-up
  always_comb begin
    if (fl_addr == UNLOCK1_ADDR && fl_dq_o == UNLOCK1_DATA)
      code_nxt = 2'h1;
    else if (fl_addr == UNLOCK2_ADDR && fl_dq_o == UNLOCK2_DATA)
      code_nxt = 2'h2;
    else if (fl_addr == fess_pkg::SETUP_ADDR &&
             fl_dq_o == fess_pkg::CMD_SETUP)
      code_nxt = 2'h3;
    else
      code_nxt = 2'h0;
  end
  assign wstb = fl_we_n & ~we_q_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      we_q_r <= 1'b1;
    else
      we_q_r <= fl_we_n;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      h1_r <= 2'h0;
      h2_r <= 2'h0;
      h3_r <= 2'h0;
    end else if (wstb) begin
      h1_r <= code_nxt;
      h2_r <= h1_r;
      h3_r <= h2_r;
    end
  end
  sequence wr_low_s;
    (!fl_we_n && !fl_ce_n && fl_dq_oe) [*2];
  endsequence
  sequence rd_low_s;
    (!fl_oe_n && !fl_ce_n && fl_we_n && !fl_dq_oe) [*4];
  endsequence
  we_pulse_a: assert property ($fell(fl_we_n) |-> wr_low_s ##1 fl_we_n)
    else $error("write pulse malformed");
  addr_hold_a: assert property (!fl_we_n |-> $stable(fl_addr))
    else $error("address moved during write pulse");
  data_rise_a: assert property (wstb |-> !fl_ce_n && $stable(fl_dq_o))
    else $error("data not held at write rise");
  setup_seq_a: assert property (wstb && fl_dq_o == 8'h80 |->
    fl_addr == 19'h05555 && h1_r == 2'h2 && h2_r == 2'h1)
    else $error("set-up code without unlock pair");
  confirm_seq_a: assert property (wstb && fl_dq_o == 8'h10 |->
    h1_r == 2'h2 && h2_r == 2'h1 && h3_r == 2'h3)
    else $error("confirm code out of order");
  single_cmd_a: assert property (wstb &&
    (fl_dq_o == 8'hb0 || fl_dq_o == 8'h30) |-> h1_r != 2'h2)
    else $error("suspend or resume after unlock");
  read_cycle_a: assert property ($fell(fl_oe_n) |-> rd_low_s ##1 fl_oe_n)
    else $error("status read cycle malformed");
  reset_idle_a: assert property ($rose(reset_n) |->
    fl_ce_n && fl_we_n && fl_oe_n && !fl_dq_oe)
    else $error("pins not idle after reset");
  lockout_a: assert property ($fell(fl_we_n) |-> !$past(supply_low, 2))
    else $error("write started under low supply");
endmodule
bind fess_ctrl fess_ctrl_assertions #(
  .UNLOCK1_ADDR(UNLOCK1_ADDR), .UNLOCK1_DATA(UNLOCK1_DATA),
  .UNLOCK2_ADDR(UNLOCK2_ADDR), .UNLOCK2_DATA(UNLOCK2_DATA)
) fess_ctrl_assertions_i (
  .sys_clk, .reset_n, .supply_low, .fl_addr, .fl_dq_o, .fl_dq_oe,
  .fl_ce_n, .fl_we_n, .fl_oe_n
);

/* File: tb/fess_flash_model.sv */
// behavioural flash device on the controller's pins
`timescale 1ns/100ps
module fess_flash_model #(
  parameter logic [18:0] U1A = 19'h05555,
  parameter logic [7:0] U1D = 8'haa,
  parameter logic [18:0] U2A = 19'h02aaa,
  parameter logic [7:0] U2D = 8'h55,
  parameter logic [7:0] RST = 8'hf0,
  parameter logic [7:0] PGM = 8'ha0
) (
  input wire logic [18:0] fl_addr,
  input wire logic [7:0] fl_dq_o,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic lockout,
  input wire logic fail_en,
  input wire logic [7:0] erase_len,
  output logic [7:0] fl_dq_i
);
  logic [18:0] la;
  logic [2:0] step = 3'h0;
  logic erasing = 1'b0, susp = 1'b0, failed = 1'b0, prog = 1'b0;
  logic tg = 1'b0, rd_on = 1'b0;
  logic [7:0] left = 8'h0, mem = 8'h5a, last = 8'h0, st;
  logic ok1, ok2;
  assign ok1 = la == U1A && fl_dq_o == U1D;
  assign ok2 = la == U2A && fl_dq_o == U2D;
  always @(negedge fl_we_n) la = fl_addr;
  always @(posedge fl_we_n) begin
    if (!fl_ce_n && !lockout) begin
      if (fl_dq_o == RST) begin
        if (susp)
          mem = ~mem; // aborted erase leaves junk
        erasing = 1'b0;
        susp = 1'b0;
        failed = 1'b0;
        step = 3'h0;
      end else if (erasing) begin // only suspend and read_reset are heard
        if (fl_dq_o == 8'hb0) begin
          erasing = 1'b0;
          susp = 1'b1;
        end
      end else if (prog || failed)
        step = 3'h0;
      else if (susp && step == 3'h0 && fl_dq_o == 8'h30) begin
        susp = 1'b0;
        erasing = 1'b1;
      end else case (step)
        3'h0, 3'h3: step = ok1 ? step + 3'h1 : 3'h0;
        3'h1, 3'h4: step = ok2 ? step + 3'h1 : 3'h0;
        3'h2: step = la != 19'h05555 ? 3'h0 : fl_dq_o == PGM ? 3'h6 :
          (fl_dq_o == 8'h80 && !susp) ? 3'h3 : 3'h0;
        3'h5: begin
          erasing = fl_dq_o == 8'h10;
          left = erase_len;
          step = 3'h0;
        end
        default: begin
          mem = fl_dq_o;
          prog = 1'b1;
          left = 8'h3;
          step = 3'h0;
        end
      endcase
    end
  end
  always @(negedge fl_oe_n) rd_on = 1'b1;
  always @(posedge fl_oe_n) begin
    if (rd_on) begin
      rd_on = 1'b0;
      last = st;
      tg = ~tg;
      if ((erasing || prog) && left != 8'h0)
        left = left - 8'h1;
      else if (erasing) begin // pre-program and erase inside
        erasing = 1'b0;
        failed = fail_en;
        mem = 8'hff;
      end else
        prog = 1'b0;
    end
  end
  always_comb begin
    if (erasing)
      st = {1'b0, tg, 2'b00, 1'b1, tg, 2'b00};
    else if (prog)
      st = {1'b0, tg, 3'b000, tg, 2'b00};
    else if (failed)
      st = {5'b01101, tg | fl_addr[18], 2'b00};
    else if (susp && !fl_addr[18])
      st = {2'b01, 3'b000, tg, 2'b00};
    else
      st = mem;
  end
  // no pull on the bus: a released line shows the inverse of the last read
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? st : ~last;
endmodule

/* File: tb/test_fess_ctrl.sv */
// self-checking bench for the flash erase/suspend controller
`timescale 1ns/100ps
module test_fess_ctrl;
  typedef struct {logic [2:0] op; logic f; logic [1:0] ph; logic [7:0] rd;}
    fess_row_s;
  logic sys_clk, reset_n, reg_wr, reg_rd, supply_low, fail_en;
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, q;
  logic [18:0] fl_addr;
  logic [7:0] fl_dq_o, fl_dq_i, erase_len;
  int error_cnt, comparisons, cyc, wfalls;
  fess_row_s rows [7] = '{'{3'h5, 1'b0, 2'h0, 8'h00},
    '{3'h6, 1'b0, 2'h0, 8'h3c}, '{3'h1, 1'b0, 2'h0, 8'h00},
    '{3'h6, 1'b0, 2'h0, 8'hff}, '{3'h1, 1'b1, 2'h3, 8'h00},
    '{3'h6, 1'b0, 2'h3, 8'h6c}, '{3'h4, 1'b0, 2'h0, 8'h00}};
  fess_ctrl fess_ctrl_i (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .supply_low, .fl_addr, .fl_dq_o, .fl_dq_oe,
    .fl_dq_i, .fl_ce_n, .fl_we_n, .fl_oe_n);
  fess_flash_model fess_flash_model_i (.fl_addr, .fl_dq_o, .fl_ce_n,
    .fl_we_n, .fl_oe_n, .lockout(supply_low), .fail_en, .erase_len,
    .fl_dq_i);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(negedge fl_we_n) wfalls++;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("ERROR %0t: run hung", $time);
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 400; i++) begin
      rd(fess_pkg::STAT_OFF);
      if ((q & m) === v)
        break;
    end
  endtask
  task automatic go(input logic [2:0] op);
    wr(fess_pkg::CTRL_OFF, {29'h0, op});
  endtask
  task automatic order(input logic [2:0] op);
    go(op);
    wait_st(32'h3, 32'h0);
  endtask
  task automatic ph_chk(input logic [1:0] p);
    check({30'h0, q[3:2]}, {30'h0, p});
  endtask
  task automatic refused();
    rd(fess_pkg::STAT_OFF);
    check({31'h0, q[4]}, 32'h1);
    wr(fess_pkg::STAT_OFF, 32'h10);
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    supply_low = 1'b0;
    fail_en = 1'b0;
    erase_len = 8'h08;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1 check({28'h0, fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe}, 32'he);
    @(posedge sys_clk);
    wr(fess_pkg::ADDR_OFF, 32'h40000);
    wr(fess_pkg::DATA_OFF, 32'h3c);
    foreach (rows[i]) begin
      fail_en <= rows[i].f;
      order(rows[i].op);
      ph_chk(rows[i].ph);
      if (rows[i].op == fess_pkg::OP_READ)
        check({24'h0, q[23:16]}, {24'h0, rows[i].rd});
      if (rows[i].op == fess_pkg::OP_ERASE)
        check({30'h0, q[15], q[13]}, {30'h0, ~rows[i].f, 1'b1});
      $display("row %0d done", i);
    end
    go(fess_pkg::OP_SUSPEND);
    refused();
    supply_low <= 1'b1;
    wfalls = 0;
    order(fess_pkg::OP_ERASE);
    refused();
    check(wfalls, 32'h0);
    supply_low <= 1'b0;
    rd(4'h2);
    check(q, 32'h0);
    $display("refusals done");
    erase_len <= 8'h40;
    wr(fess_pkg::ADDR_OFF, 32'h0);
    go(fess_pkg::OP_ERASE);
    wait_st(32'hc, 32'h4);
    order(fess_pkg::OP_SUSPEND);
    ph_chk(2'h2);
    check({31'h0, q[14]}, 32'h1);
    wr(fess_pkg::ADDR_OFF, 32'h40000);
    wr(fess_pkg::DATA_OFF, 32'hc3);
    order(fess_pkg::OP_PROG);
    order(fess_pkg::OP_READ);
    check({24'h0, q[23:16]}, 32'hc3);
    go(fess_pkg::OP_ERASE);
    refused();
    order(fess_pkg::OP_RESUME);
    ph_chk(2'h0);
    $display("suspend and resume done");
    go(fess_pkg::OP_ERASE);
    wait_st(32'hc, 32'h4);
    order(fess_pkg::OP_SUSPEND);
    order(fess_pkg::OP_RESET);
    ph_chk(2'h0);
    $display("abort done");
    summarize();
  end
endmodule
